// file: core/ccs_pkg.sv
package ccs_pkg;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int SS_HOLD_US = 240;
  localparam int SS_HOLD_CYC_DEF = SS_HOLD_US * CLK_MHZ;
  localparam int DCM_HOLD_MULT = 4;
  localparam int MS_TICK_CYC_DEF = CLK_MHZ * 1000;
  localparam int OC_BLANK_US = 2500;
  localparam int OC_BLANK_CYC_DEF = OC_BLANK_US * CLK_MHZ;
  localparam int SW_FREQ_KHZ = 750;
  localparam int PWM_PERIOD_CYC = (CLK_MHZ * 1000) / SW_FREQ_KHZ;
  localparam int MAX_DUTY_PERMILLE = 995;
  localparam int MAX_ON_CYC = (PWM_PERIOD_CYC * MAX_DUTY_PERMILLE) / 1000;
  localparam int DEAD_NS = 10;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int REFRESH_NS = 100;
  localparam int REFRESH_CYC = (REFRESH_NS * CLK_MHZ + 999) / 1000;

  // Millisecond counts and fault limit
  localparam logic [17:0] WD_44_MS = 18'h0ABE0;
  localparam logic [17:0] WD_88_MS = 18'h157C0;
  localparam logic [17:0] WD_175_MS = 18'h2AB98;
  localparam logic [10:0] OC_RETRY_MS = 11'h514;
  localparam logic [16:0] OC_WINDOW_MS = 17'h15F90;
  localparam logic [2:0] OC_FAULT_LIMIT = 3'h7;

  // Soft-start currents in mA
  localparam logic [15:0] SS_START_MA = 16'h0080;
  localparam logic [15:0] SS_STEP_CCM_MA = 16'h0040;
  localparam logic [15:0] SS_STEP_DCM_MA = 16'h0080;

  // Register offsets
  localparam logic [7:0] OFS_OPTION = 8'h00;
  localparam logic [7:0] OFS_CUR_LIMIT = 8'h04;
  localparam logic [7:0] OFS_VOLT_LIMIT = 8'h08;
  localparam logic [7:0] OFS_IN_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_TARGET = 8'h14;

  // Option word fields and reset values
  localparam int OPT_INHIBIT_BIT = 0;
  localparam int OPT_OCP_LSB = 1;
  localparam int OPT_MON_SEL_BIT = 5;
  localparam int OPT_WD_LSB = 13;
  localparam logic [15:0] OPT_RESET = 16'h6004;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [1:0] WD_OFF = 2'h0;
  localparam logic [1:0] WD_44 = 2'h1;
  localparam logic [1:0] WD_88 = 2'h2;
  localparam logic [1:0] OCP_OFF = 2'h0;

  typedef struct packed {
    logic vcc_ok;
    logic adapter_ok;
    logic ramp_above_error;
    logic bootstrap_low;
    logic under_current;
    logic avg_below_low;
    logic avg_above_high;
    logic battery_low;
    logic input_overcurrent;
  } ccs_sense_s;

endpackage

// file: core/ccs_sync.sv
module ccs_sync
  import ccs_pkg::*;
#(
  parameter int WIDTH = 9
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Two flip-flops per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          stage1[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

// file: core/ccs_switch_seq.sv
module ccs_switch_seq
  import ccs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sreset,
  input wire logic run,
  input wire logic nonsync,
  input wire logic ramp_above_error,
  input wire logic bootstrap_low,
  input wire logic under_current,
  output logic high_side_switch,
  output logic low_side_switch,
  output logic discontinuous_conduction
);

  typedef enum logic [2:0] {S_IDLE, S_DEAD_H, S_HS, S_DEAD_L, S_LS, S_OFF} ccs_sw_e;

  ccs_sw_e state;
  ccs_sw_e next_state;
  logic [8:0] pc;
  logic [4:0] dcnt;
  logic refresh;
  logic ucp_seen;

  wire cyc_end = pc == 9'(PWM_PERIOD_CYC - 1);
  wire dead_done = dcnt == 5'(DEAD_CYC - 1);
  wire refresh_done = dcnt == 5'(REFRESH_CYC - 1);
  wire ls_normal = !nonsync && !under_current;
  wire next_refresh = (state == S_DEAD_L) ? (bootstrap_low && !ls_normal) : refresh;

  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE: if (run && cyc_end) next_state = S_DEAD_H;
      // Zero duty when the ramp offset already sits above the error signal
      S_DEAD_H: if (dead_done) next_state = (ramp_above_error || !run) ? S_DEAD_L : S_HS;
      // High side holds while error exceeds ramp, capped at max duty
      S_HS: if (ramp_above_error || !run || pc >= 9'(MAX_ON_CYC)) next_state = S_DEAD_L;
      S_DEAD_L:
        if (dead_done)
          next_state = !run ? S_IDLE : (ls_normal || bootstrap_low) ? S_LS : S_OFF;
      S_LS:
        if (cyc_end)
          next_state = S_DEAD_H;
        else if (refresh ? refresh_done : (under_current || nonsync || !run))
          next_state = S_OFF;
      S_OFF: if (cyc_end || !run) next_state = run ? S_DEAD_H : S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      pc <= 9'h000;
      dcnt <= 5'h00;
      refresh <= 1'b0;
      ucp_seen <= 1'b0;
      discontinuous_conduction <= 1'b0;
      high_side_switch <= 1'b0;
      low_side_switch <= 1'b0;
    end
    else if (sreset)
    begin
      state <= S_IDLE;
      pc <= 9'h000;
      dcnt <= 5'h00;
      refresh <= 1'b0;
      ucp_seen <= 1'b0;
      discontinuous_conduction <= 1'b0;
      high_side_switch <= 1'b0;
      low_side_switch <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pc <= cyc_end ? 9'h000 : pc + 9'h001;
      dcnt <= (next_state != state) ? 5'h00 : dcnt + 5'h01;
      refresh <= next_refresh;
      ucp_seen <= cyc_end ? 1'b0 : (ucp_seen || (state == S_LS && under_current));
      if (cyc_end)
        discontinuous_conduction <= ucp_seen;
      high_side_switch <= next_state == S_HS;
      low_side_switch <= next_state == S_LS;
    end
  end

  property p_no_overlap;
    @(posedge pclk) disable iff (!presetn)
    !(high_side_switch && low_side_switch);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both switches on");

  property p_dead_after_hs;
    @(posedge pclk) disable iff (!presetn)
    $fell(high_side_switch) |-> !low_side_switch ##1 !low_side_switch;
  endproperty
  a_dead_after_hs: assert property (p_dead_after_hs) else $error("no dead time");

  property p_nonsync_refresh_only;
    @(posedge pclk) disable iff (!presetn || sreset)
    (nonsync && $rose(low_side_switch) && $past(nonsync)) |-> refresh;
  endproperty
  a_nonsync_refresh_only: assert property (p_nonsync_refresh_only) else $error("ls on nonsync");

endmodule

// file: core/ccs_top.sv
// Operation
// - Soft-start ramps charge current whenever charging enables
// - Ramp starts 128mA, steps 64mA in continuous
// - Hold each step 240us, stop at limit
// - Discontinuous ramp: larger steps, longer hold
// - Option bit picks input or charge current monitor
// - Monitor active only above lockout and adapter threshold
// - Watchdog suspends charge without limit writes
// - Watchdog expiry keeps all register contents
// - Charge current or voltage limit write restarts watchdog and resumes charge
// - Two-bit field: watchdog off, 44s, 88s, 175s
// - Disabling watchdog after expiry resumes charging
// - Ramp offset allows zero duty; high side capped below full duty
// - Low bootstrap triggers refresh; duty capped 99.5%
// - High side on until ramp crosses error
// - Dead time on every switch transition
// - Under-current comparator turns low side off
// - Non-synchronous below 125mA or 2.5V battery
// - Non-synchronous: low side only refresh pulses
// - Back to synchronous above 250mA
// - Overcurrent past 2.5ms blanks adapter for 1.3s
// - Seven faults in 90s latch adapter off
// - Two-bit field sets overcurrent threshold or off
// - Inhibit bit stops charge; clearing triggers soft-start
//
// The register addresses and the APB slave port were left to the implementer.
module ccs_top
  import ccs_pkg::*;
#(
  parameter int SS_HOLD_CYC = SS_HOLD_CYC_DEF,
  parameter int MS_TICK_CYC = MS_TICK_CYC_DEF,
  parameter int OC_BLANK_CYC = OC_BLANK_CYC_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ccs_sense_s sense_in,
  output logic high_side_switch,
  output logic low_side_switch,
  output logic adapter_series_switch,
  output logic current_monitor_enable,
  output logic current_monitor_select,
  output logic [1:0] oc_threshold_sel,
  output logic [15:0] charge_current_target,
  output logic charging
);

  ccs_sense_s sense;
  logic [15:0] charger_option_word;
  logic [15:0] charge_current_limit;
  logic [15:0] charge_voltage_limit;
  logic [15:0] input_current_limit;
  logic [17:0] ms_cnt;
  logic [17:0] wd_cnt;
  logic wd_expired;
  logic ss_active;
  logic [19:0] ss_cnt;
  logic nonsync;
  logic [18:0] blank_cnt;
  logic oc_retry;
  logic [10:0] retry_cnt;
  logic [2:0] fault_cnt;
  logic [16:0] window_cnt;
  logic latched;
  logic discontinuous_conduction;

  ccs_sync #(.WIDTH($bits(ccs_sense_s))) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sense_in),
    .sync_out(sense)
  );

  // Device reset while supply or adapter detect is low
  wire sreset = !sense.vcc_ok || !sense.adapter_ok;

  // Bus decode
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pready && pwrite;
  wire hit_opt = paddr == OFS_OPTION;
  wire hit_cur = paddr == OFS_CUR_LIMIT;
  wire hit_volt = paddr == OFS_VOLT_LIMIT;
  wire hit_in = paddr == OFS_IN_LIMIT;
  wire hit_stat = paddr == OFS_STATUS;
  wire hit_tgt = paddr == OFS_TARGET;
  wire mapped = hit_opt || hit_cur || hit_volt || hit_in || hit_stat || hit_tgt;
  wire wr_opt = wr_en && hit_opt;
  wire wr_cur = wr_en && hit_cur;
  wire wr_volt = wr_en && hit_volt;
  wire wr_in = wr_en && hit_in;
  wire bad_access = !mapped || (pwrite && (hit_stat || hit_tgt));

  wire [1:0] wd_sel = charger_option_word[OPT_WD_LSB+1:OPT_WD_LSB];
  wire [1:0] ocp_sel = charger_option_word[OPT_OCP_LSB+1:OPT_OCP_LSB];
  wire [1:0] next_wd_sel = pwdata[OPT_WD_LSB+1:OPT_WD_LSB];
  wire [31:0] status_word = {21'h000000, fault_cnt, 2'h0, ss_active, nonsync, latched,
    oc_retry, wd_expired, charging};
  wire [15:0] rd_mux = hit_opt ? charger_option_word :
                       hit_cur ? charge_current_limit :
                       hit_volt ? charge_voltage_limit :
                       hit_in ? input_current_limit :
                       hit_tgt ? charge_current_target : 16'h0000;
  wire [31:0] next_prdata = hit_stat ? status_word : {16'h0000, rd_mux};

  // Zero-wait APB slave, answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && bad_access;
      prdata <= (setup && !pwrite && mapped) ? next_prdata : 32'h00000000;
    end
  end

  // Registers; watchdog expiry never touches them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      charger_option_word <= OPT_RESET;
      charge_current_limit <= LIMIT_RESET;
      charge_voltage_limit <= LIMIT_RESET;
      input_current_limit <= LIMIT_RESET;
    end
    else if (sreset)
    begin
      charger_option_word <= OPT_RESET;
      charge_current_limit <= LIMIT_RESET;
      charge_voltage_limit <= LIMIT_RESET;
      input_current_limit <= LIMIT_RESET;
    end
    else
    begin
      if (wr_opt)
        charger_option_word <= pwdata[15:0];
      if (wr_cur)
        charge_current_limit <= pwdata[15:0];
      if (wr_volt)
        charge_voltage_limit <= pwdata[15:0];
      if (wr_in)
        input_current_limit <= pwdata[15:0];
    end
  end

  // Millisecond tick and watchdog
  wire ms_tick = ms_cnt == 18'(MS_TICK_CYC - 1);
  wire [17:0] wd_limit = (wd_sel == WD_44) ? WD_44_MS : (wd_sel == WD_88) ? WD_88_MS : WD_175_MS;
  wire wd_restart = wr_cur || wr_volt;
  wire wd_off_write = wr_opt && next_wd_sel == WD_OFF;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ms_cnt <= 18'h00000;
      wd_cnt <= 18'h00000;
      wd_expired <= 1'b0;
    end
    else if (sreset)
    begin
      ms_cnt <= 18'h00000;
      wd_cnt <= 18'h00000;
      wd_expired <= 1'b0;
    end
    else
    begin
      ms_cnt <= ms_tick ? 18'h00000 : ms_cnt + 18'h00001;
      if (wd_restart || wd_off_write || wd_sel == WD_OFF)
      begin
        wd_cnt <= 18'h00000;
        wd_expired <= 1'b0;
      end
      else if (ms_tick && !wd_expired)
      begin
        wd_cnt <= wd_cnt + 18'h00001;
        if (wd_cnt == wd_limit - 18'h00001)
          wd_expired <= 1'b1;
      end
    end
  end

  // Charge enable
  wire limits_ok = charge_current_limit != 16'h0000 && charge_voltage_limit != 16'h0000
    && input_current_limit != 16'h0000;
  wire next_charging = !charger_option_word[OPT_INHIBIT_BIT] && !wd_expired && !oc_retry
    && !latched && limits_ok;
  wire en_rise = next_charging && !charging;

  // Soft-start stepping
  wire [19:0] hold_cyc = discontinuous_conduction ? 20'(SS_HOLD_CYC * DCM_HOLD_MULT) : 20'(SS_HOLD_CYC);
  wire [15:0] step_ma = discontinuous_conduction ? SS_STEP_DCM_MA : SS_STEP_CCM_MA;
  wire [16:0] stepped = {1'b0, charge_current_target} + {1'b0, step_ma};
  wire step_due = ss_active && ss_cnt >= hold_cyc - 20'h00001;
  wire reach = stepped >= {1'b0, charge_current_limit};
  wire [15:0] ss_first = (charge_current_limit < SS_START_MA) ? charge_current_limit : SS_START_MA;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      charging <= 1'b0;
      ss_active <= 1'b0;
      ss_cnt <= 20'h00000;
      charge_current_target <= 16'h0000;
    end
    else if (sreset || !next_charging)
    begin
      charging <= 1'b0;
      ss_active <= 1'b0;
      ss_cnt <= 20'h00000;
      charge_current_target <= 16'h0000;
    end
    else if (en_rise)
    begin
      charging <= 1'b1;
      ss_active <= charge_current_limit > SS_START_MA;
      ss_cnt <= 20'h00000;
      charge_current_target <= ss_first;
    end
    else if (step_due)
    begin
      ss_cnt <= 20'h00000;
      ss_active <= !reach;
      charge_current_target <= reach ? charge_current_limit : stepped[15:0];
    end
    else if (ss_active)
      ss_cnt <= ss_cnt + 20'h00001;
    else
      charge_current_target <= charge_current_limit;
  end

  // Synchronous / non-synchronous hysteresis
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nonsync <= 1'b1;
    else if (sreset)
      nonsync <= 1'b1;
    else if (sense.avg_below_low || sense.battery_low)
      nonsync <= 1'b1;
    else if (sense.avg_above_high)
      nonsync <= 1'b0;
  end

  // Input overcurrent: blanking, retry, fault window, latch-off
  wire oc_active = ocp_sel != OCP_OFF && sense.input_overcurrent && !oc_retry && !latched;
  wire oc_fault = oc_active && blank_cnt == 19'(OC_BLANK_CYC - 1);
  wire window_end = ms_tick && fault_cnt != 3'h0 && window_cnt == OC_WINDOW_MS - 17'h00001;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blank_cnt <= 19'h00000;
      oc_retry <= 1'b0;
      retry_cnt <= 11'h000;
      fault_cnt <= 3'h0;
      window_cnt <= 17'h00000;
      latched <= 1'b0;
    end
    else if (sreset)
    begin
      blank_cnt <= 19'h00000;
      oc_retry <= 1'b0;
      retry_cnt <= 11'h000;
      fault_cnt <= 3'h0;
      window_cnt <= 17'h00000;
      latched <= 1'b0;
    end
    else
    begin
      blank_cnt <= (oc_active && !oc_fault) ? blank_cnt + 19'h00001 : 19'h00000;
      if (oc_fault)
      begin
        oc_retry <= 1'b1;
        retry_cnt <= 11'h000;
      end
      else if (oc_retry && ms_tick)
      begin
        retry_cnt <= retry_cnt + 11'h001;
        if (retry_cnt == OC_RETRY_MS - 11'h001)
          oc_retry <= 1'b0;
      end
      if (oc_fault)
      begin
        fault_cnt <= fault_cnt + 3'h1;
        if (fault_cnt == OC_FAULT_LIMIT - 3'h1)
          latched <= 1'b1;
        if (fault_cnt == 3'h0)
          window_cnt <= 17'h00000;
      end
      else if (window_end)
      begin
        fault_cnt <= 3'h0;
        window_cnt <= 17'h00000;
      end
      else if (ms_tick && fault_cnt != 3'h0)
        window_cnt <= window_cnt + 17'h00001;
    end
  end

  // Pin-level outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adapter_series_switch <= 1'b0;
      current_monitor_enable <= 1'b0;
      current_monitor_select <= 1'b0;
      oc_threshold_sel <= OCP_OFF;
    end
    else
    begin
      adapter_series_switch <= !sreset && !oc_retry && !latched && !oc_fault;
      current_monitor_enable <= !sreset;
      current_monitor_select <= charger_option_word[OPT_MON_SEL_BIT];
      oc_threshold_sel <= ocp_sel;
    end
  end

  ccs_switch_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .sreset(sreset),
    .run(charging),
    .nonsync(nonsync),
    .ramp_above_error(sense.ramp_above_error),
    .bootstrap_low(sense.bootstrap_low),
    .under_current(sense.under_current),
    .high_side_switch(high_side_switch),
    .low_side_switch(low_side_switch),
    .discontinuous_conduction(discontinuous_conduction)
  );

  property p_ss_start;
    @(posedge pclk) disable iff (!presetn)
    $rose(charging) |-> charge_current_target == ss_first;
  endproperty
  a_ss_start: assert property (p_ss_start) else $error("soft-start start wrong");

  property p_ss_step;
    @(posedge pclk) disable iff (!presetn)
    (step_due && next_charging && !en_rise && !sreset && !reach)
      |=> charge_current_target == $past(charge_current_target) + $past(step_ma);
  endproperty
  a_ss_step: assert property (p_ss_step) else $error("soft-start step wrong");

  property p_ss_cap;
    @(posedge pclk) disable iff (!presetn)
    charging |-> charge_current_target <= $past(charge_current_limit) || $rose(charging);
  endproperty
  a_ss_cap: assert property (p_ss_cap) else $error("target above limit");

  property p_mon_sel;
    @(posedge pclk) disable iff (!presetn)
    (wr_opt && !sreset) |=> ##1 current_monitor_select == $past(pwdata[OPT_MON_SEL_BIT], 2);
  endproperty
  a_mon_sel: assert property (p_mon_sel) else $error("monitor select wrong");

  property p_mon_en;
    @(posedge pclk) disable iff (!presetn)
    !sense.adapter_ok |=> !current_monitor_enable;
  endproperty
  a_mon_en: assert property (p_mon_en) else $error("monitor on without adapter");

  property p_wd_suspend;
    @(posedge pclk) disable iff (!presetn)
    wd_expired |=> !charging;
  endproperty
  a_wd_suspend: assert property (p_wd_suspend) else $error("charging after expiry");

  property p_wd_keep;
    @(posedge pclk) disable iff (!presetn)
    $rose(wd_expired) |-> $stable(charge_current_limit) && $stable(charger_option_word);
  endproperty
  a_wd_keep: assert property (p_wd_keep) else $error("registers changed on expiry");

  property p_wd_restart;
    @(posedge pclk) disable iff (!presetn)
    (wd_restart || wd_off_write) |=> !wd_expired && wd_cnt == 18'h00000;
  endproperty
  a_wd_restart: assert property (p_wd_restart) else $error("watchdog not restarted");

  property p_retry_off;
    @(posedge pclk) disable iff (!presetn)
    oc_fault |=> oc_retry && !adapter_series_switch;
  endproperty
  a_retry_off: assert property (p_retry_off) else $error("adapter switch on in retry");

  property p_latch;
    @(posedge pclk) disable iff (!presetn)
    (oc_fault && fault_cnt == 3'h6 && !sreset) |=> latched ##1 !adapter_series_switch;
  endproperty
  a_latch: assert property (p_latch) else $error("no latch on seventh fault");

endmodule

// file: sim/ccs_plant.sv
module ccs_plant
  import ccs_pkg::*;
(
  input wire logic pclk,
  input wire logic low_side_switch,
  output logic ramp_above_error,
  output logic bootstrap_low
);
  timeunit 1ns;
  timeprecision 1ps;
  int ramp = 0;
  int idle = 0;
  // Sawtooth ramp against a mid-level error signal
  always @(posedge pclk)
  begin
    ramp <= (ramp == PWM_PERIOD_CYC - 1) ? 0 : ramp + 1;
    idle <= low_side_switch ? 0 : idle + 1;
  end
  assign ramp_above_error = ramp > PWM_PERIOD_CYC / 2;
  // Bootstrap sags after long low-side idle
  assign bootstrap_low = idle > 4 * PWM_PERIOD_CYC;
endmodule

// file: sim/ccs_top_bench.sv
module ccs_top_bench;
  import ccs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SS = 20;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, hs, ls, acsw, mon_en, mon_sel, chg, rae, btl, er;
  logic [1:0] ocsel;
  logic [15:0] tgt;
  logic [31:0] rd;
  logic [8:0] sn = 9'h180;
  ccs_sense_s sense;
  int mismatches = 0;
  int total_checks = 0;
  int hs_on = 0;
  int ls_run = 0;
  int n;
  assign sense = {sn[8:7], rae, btl, sn[4:0]};
  ccs_top #(.SS_HOLD_CYC(SS), .MS_TICK_CYC(1), .OC_BLANK_CYC(8)) u_ccs_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense_in(sense),
    .high_side_switch(hs), .low_side_switch(ls), .adapter_series_switch(acsw),
    .current_monitor_enable(mon_en), .current_monitor_select(mon_sel),
    .oc_threshold_sel(ocsel), .charge_current_target(tgt), .charging(chg));
  ccs_plant u_ccs_plant (.pclk(pclk), .low_side_switch(ls),
    .ramp_above_error(rae), .bootstrap_low(btl));
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Waits for charging (k=0) or adapter switch (k=1) to reach v
  task automatic wait_on(input int k, input logic v, input int lim);
    n = 0;
    while (((k == 1) ? acsw : chg) !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk((k == 1) ? acsw : chg, v);
  endtask
  // Overlap and low-side pulse width watch; bench never leaves nonsync
  always @(posedge pclk)
  begin
    if (hs === 1'b1 && ls === 1'b1)
      chk(0, 1);
    if (hs === 1'b1)
      hs_on++;
    ls_run = (ls === 1'b1) ? ls_run + 1 : 0;
    if (ls_run > REFRESH_CYC)
      chk(ls_run, REFRESH_CYC);
  end
  task automatic t_regs();
    apb(1'b0, OFS_OPTION, 32'h0);
    chk(rd, OPT_RESET);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h1);
    chk(er, 1'b1);
    chk(chg, 1'b0);
  endtask
  task automatic t_soft();
    apb(1'b1, OFS_VOLT_LIMIT, 32'h3000);
    apb(1'b1, OFS_IN_LIMIT, 32'h0800);
    apb(1'b1, OFS_CUR_LIMIT, 32'h0100);
    wait_on(0, 1'b1, 10);
    chk(tgt, SS_START_MA);
    cyc(SS / 2);
    chk(tgt, 16'h0080);
    cyc(SS);
    chk(tgt, 16'h00C0);
    cyc(2 * SS);
    chk(tgt, 16'h0100);
    cyc(2 * PWM_PERIOD_CYC);
    chk(hs_on > 0, 1'b1);
    apb(1'b1, OFS_OPTION, {16'h0, OPT_RESET | 16'h0001});
    cyc(2);
    chk({chg, tgt}, 17'h0);
    apb(1'b1, OFS_OPTION, {16'h0, OPT_RESET});
    wait_on(0, 1'b1, 10);
    chk(tgt, 16'h0080);
  endtask
  task automatic t_mon();
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, OFS_OPTION, (k << 1) | ((k & 1) << 5));
      cyc(1);
      chk(ocsel, k);
      chk(mon_sel, k & 1);
    end
  endtask
  task automatic t_wd();
    apb(1'b1, OFS_OPTION, 32'h2024);
    apb(1'b1, OFS_CUR_LIMIT, 32'h0100);
    cyc(43900);
    chk(chg, 1'b1);
    wait_on(0, 1'b0, 200);
    apb(1'b0, OFS_OPTION, 32'h0);
    chk(rd, 32'h2024);
    apb(1'b0, OFS_CUR_LIMIT, 32'h0);
    chk(rd, 32'h0100);
    apb(1'b1, OFS_CUR_LIMIT, 32'h0100);
    wait_on(0, 1'b1, 5);
  endtask
  task automatic t_oc();
    apb(1'b1, OFS_OPTION, 32'h0);
    sn[0] <= 1'b1;
    cyc(40);
    chk(acsw, 1'b1);
    sn[0] <= 1'b0;
    apb(1'b1, OFS_OPTION, 32'h4);
    for (int i = 0; i < 7; i++)
    begin
      sn[0] <= 1'b1;
      wait_on(1, 1'b0, 30);
      cyc(1);
      chk(chg, 1'b0);
      sn[0] <= 1'b0;
      if (i < 6)
      begin
        wait_on(1, 1'b1, 1400);
        chk(n > 1250, 1'b1);
        wait_on(0, 1'b1, 10);
        chk(tgt, 16'h0080);
      end
    end
    cyc(1500);
    chk(acsw, 1'b0);
    sn[7] <= 1'b0;
    cyc(6);
    chk(mon_en, 1'b0);
    sn[7] <= 1'b1;
    cyc(8);
    chk({mon_en, acsw}, 2'h3);
    apb(1'b0, OFS_OPTION, 32'h0);
    chk(rd, OPT_RESET);
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #400000;
    mismatches++;
    end_sim();
  end
  initial
  begin
    cyc(20);
    presetn <= 1'b1;
    cyc(4);
    t_regs();
    t_soft();
    t_mon();
    t_wd();
    t_oc();
    end_sim();
  end
endmodule
